// [verilog/cssu_clock_ctrl.sv]
/*
 * Clock source select and start-up sequencer: decodes the clock fuses,
 * times start-up on source and watchdog oscillator ticks, and drives the
 * enables of the five clock domains from the sleep mode.
 * Assumes fuse levels, the source and watchdog oscillator pins and the
 * wake event arrive unsynchronised; sleep requests come from clk logic.
 */
`timescale 1ns/1ps
`include "cssu_regs.svh"
module cssu_clock_ctrl #(
    parameter logic [`CSSU_CNT_W-1:0] SRC_CYC_16K  = `CSSU_CYC_16K,
    parameter logic [`CSSU_CNT_W-1:0] SRC_CYC_32K  = `CSSU_CYC_32K,
    parameter logic [`CSSU_CNT_W-1:0] WDT_CYC_64K  = `CSSU_WDT_CYC_64K
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rstn,
    // fuse levels
    input  wire logic [`CSSU_SEL_W-1:0]      clockSourceSelectFuses,
    input  wire logic [`CSSU_SUT_W-1:0]      startupTimeFuses,
    input  wire logic                        amplifierSwingOption,
    // oscillator ticks seen as pins
    input  wire logic                        sourceOscPin,
    input  wire logic                        watchdogOscPin,
    // sleep control
    input  wire logic                        sleepReq,
    input  wire cssu_pkg::cssu_sleep_t       sleepMode,
    input  wire logic                        wakeEvent,
    // domain enables and status
    output cssu_pkg::cssu_domains_t          domainEn,
    output logic                             startupBusy,
    output logic                             asyncIrqSenseEn,
    output logic                             twoWireAsyncMatchEn,
    // decoded oscillator configuration
    output cssu_pkg::cssu_src_kind_t         sourceKind,
    output cssu_pkg::cssu_range_t            freqRange,
    output logic                             fullSwingMode,
    output logic                             cfgReserved
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [`CSSU_SEL_W-1:0] selMeta_q, selSync_q;
    logic [`CSSU_SUT_W-1:0] sutMeta_q, sutSync_q;
    logic                   ampMeta_q, ampSync_q;
    logic [2:0]             srcPipe_q, wdtPipe_q, wakePipe_q;
    logic                   srcTick, wdtTick, wakeLvl;

    // fuse levels are static, two flops are enough to tame them
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            selMeta_q <= `CSSU_SHIP_SEL;
            selSync_q <= `CSSU_SHIP_SEL;
            sutMeta_q <= `CSSU_SHIP_SUT;
            sutSync_q <= `CSSU_SHIP_SUT;
            ampMeta_q <= `CSSU_SHIP_AMP;
            ampSync_q <= `CSSU_SHIP_AMP;
        end else begin
            selMeta_q <= clockSourceSelectFuses;
            selSync_q <= selMeta_q;
            sutMeta_q <= startupTimeFuses;
            sutSync_q <= sutMeta_q;
            ampMeta_q <= amplifierSwingOption;
            ampSync_q <= ampMeta_q;
        end
    end

    // bit 0 is the metastable stage; edges are taken on bits 1 and 2 only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            srcPipe_q  <= 3'h0;
            wdtPipe_q  <= 3'h0;
            wakePipe_q <= 3'h0;
        end else begin
            srcPipe_q  <= {srcPipe_q[1:0], sourceOscPin};
            wdtPipe_q  <= {wdtPipe_q[1:0], watchdogOscPin};
            wakePipe_q <= {wakePipe_q[1:0], wakeEvent};
        end
    end

    // oscillators must stay below half of clk or ticks are lost
    assign srcTick = srcPipe_q[1] & ~srcPipe_q[2];
    assign wdtTick = wdtPipe_q[1] & ~wdtPipe_q[2];
    assign wakeLvl = wakePipe_q[1];

    // ************************************************************
    // fuse capture and decode
    // ************************************************************
    cssu_pkg::cssu_state_t   state_q, state_d;
    logic [`CSSU_SEL_W-1:0]  fuseSel_q;
    logic [`CSSU_SUT_W-1:0]  fuseSut_q;
    logic                    fuseAmp_q;
    logic [1:0]              settle_q;
    cssu_pkg::cssu_startup_t startCfg;

    // shipped values stand until the synchronised fuses are caught
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fuseSel_q <= `CSSU_SHIP_SEL;
            fuseSut_q <= `CSSU_SHIP_SUT;
            fuseAmp_q <= `CSSU_SHIP_AMP;
            settle_q  <= 2'h0;
        end else if (state_q == cssu_pkg::ST_CAPTURE) begin
            settle_q  <= settle_q + 2'h1;
            fuseSel_q <= selSync_q;
            fuseSut_q <= sutSync_q;
            fuseAmp_q <= ampSync_q;
        end
    end

    // start-up table per source kind, fuse code sut
    function automatic cssu_pkg::cssu_startup_t decodeStartup(
        input logic [`CSSU_SEL_W-1:0] sel,
        input logic [`CSSU_SUT_W-1:0] sut
    );
        cssu_pkg::cssu_startup_t r;
        r = '{cssu_pkg::CNT_6, cssu_pkg::EXTRA_NONE, 1'b0};
        if (sel >= `CSSU_SEL_XTAL_MIN && !sel[0]) begin
            case (sut)
                2'h0:    r = '{cssu_pkg::CNT_258, cssu_pkg::EXTRA_4K, 1'b0};
                2'h1:    r = '{cssu_pkg::CNT_258, cssu_pkg::EXTRA_64K, 1'b0};
                2'h2:    r = '{cssu_pkg::CNT_1K, cssu_pkg::EXTRA_NONE, 1'b0};
                default: r = '{cssu_pkg::CNT_1K, cssu_pkg::EXTRA_4K, 1'b0};
            endcase
        end else if (sel >= `CSSU_SEL_XTAL_MIN) begin
            case (sut)
                2'h0:    r = '{cssu_pkg::CNT_1K, cssu_pkg::EXTRA_64K, 1'b0};
                2'h1:    r = '{cssu_pkg::CNT_16K, cssu_pkg::EXTRA_NONE, 1'b0};
                2'h2:    r = '{cssu_pkg::CNT_16K, cssu_pkg::EXTRA_4K, 1'b0};
                default: r = '{cssu_pkg::CNT_16K, cssu_pkg::EXTRA_64K, 1'b0};
            endcase
        end else if (sel == `CSSU_SEL_LFXTAL) begin
            case (sut)
                2'h0:    r = '{cssu_pkg::CNT_1K, cssu_pkg::EXTRA_4K, 1'b0};
                2'h1:    r = '{cssu_pkg::CNT_1K, cssu_pkg::EXTRA_64K, 1'b0};
                2'h2:    r = '{cssu_pkg::CNT_32K, cssu_pkg::EXTRA_64K, 1'b0};
                default: r = '{cssu_pkg::CNT_32K, cssu_pkg::EXTRA_64K, 1'b1};
            endcase
        end else if (sel >= `CSSU_SEL_EXTRC_MIN) begin
            case (sut)
                2'h0:    r = '{cssu_pkg::CNT_18, cssu_pkg::EXTRA_NONE, 1'b0};
                2'h1:    r = '{cssu_pkg::CNT_18, cssu_pkg::EXTRA_4K, 1'b0};
                2'h2:    r = '{cssu_pkg::CNT_18, cssu_pkg::EXTRA_64K, 1'b0};
                default: r = '{cssu_pkg::CNT_6, cssu_pkg::EXTRA_4K, 1'b0};
            endcase
        end else begin
            // internal RC and external clock share one table; 11 is reserved
            case (sut)
                2'h0:    r = '{cssu_pkg::CNT_6, cssu_pkg::EXTRA_NONE, 1'b0};
                2'h1:    r = '{cssu_pkg::CNT_6, cssu_pkg::EXTRA_4K, 1'b0};
                2'h2:    r = '{cssu_pkg::CNT_6, cssu_pkg::EXTRA_64K, 1'b0};
                default: r = '{cssu_pkg::CNT_6, cssu_pkg::EXTRA_64K, 1'b1};
            endcase
        end
        return r;
    endfunction

    assign startCfg = decodeStartup(fuseSel_q, fuseSut_q);

    // source kind, amplifier mode and crystal range; a zero bit is programmed
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sourceKind    <= cssu_pkg::SRC_INTRC;
            freqRange     <= cssu_pkg::RNG_NONE;
            fullSwingMode <= 1'b0;
            cfgReserved   <= 1'b0;
        end else begin
            if (fuseSel_q >= `CSSU_SEL_XTAL_MIN)
                sourceKind <= cssu_pkg::SRC_XTAL;
            else if (fuseSel_q == `CSSU_SEL_LFXTAL)
                sourceKind <= cssu_pkg::SRC_LFXTAL;
            else if (fuseSel_q >= `CSSU_SEL_EXTRC_MIN)
                sourceKind <= cssu_pkg::SRC_EXTRC;
            else if (fuseSel_q >= `CSSU_SEL_INTRC_MIN)
                sourceKind <= cssu_pkg::SRC_INTRC;
            else
                sourceKind <= cssu_pkg::SRC_EXTCLK;
            fullSwingMode <= (fuseAmp_q == `CSSU_FUSE_PROG);
            if (fuseSel_q < `CSSU_SEL_XTAL_MIN)
                freqRange <= cssu_pkg::RNG_NONE;
            else if (fuseAmp_q == `CSSU_FUSE_PROG)
                freqRange <= cssu_pkg::RNG_1M0_UP;
            else if (fuseSel_q[3:1] == `CSSU_RANGE_LO_CODE)
                freqRange <= cssu_pkg::RNG_0M4_0M9;
            else if (fuseSel_q[3:1] == `CSSU_RANGE_MID_CODE)
                freqRange <= cssu_pkg::RNG_0M9_3M0;
            else
                freqRange <= cssu_pkg::RNG_3M0_8M0;
            cfgReserved <= startCfg.reserved;
        end
    end

    // ************************************************************
    // start-up sequencer
    // ************************************************************
    logic [`CSSU_CNT_W-1:0] cnt_q, srcLast, wdtLast;
    logic                   fromReset_q;
    cssu_pkg::cssu_sleep_t  mode_q;
    logic                   srcDone, wdtDone;

    always_comb begin
        case (startCfg.srcCnt)
            cssu_pkg::CNT_6:   srcLast = `CSSU_CYC_6 - 17'h00001;
            cssu_pkg::CNT_18:  srcLast = `CSSU_CYC_18 - 17'h00001;
            cssu_pkg::CNT_258: srcLast = `CSSU_CYC_258 - 17'h00001;
            cssu_pkg::CNT_1K:  srcLast = `CSSU_CYC_1K - 17'h00001;
            cssu_pkg::CNT_16K: srcLast = SRC_CYC_16K - 17'h00001;
            default:           srcLast = SRC_CYC_32K - 17'h00001;
        endcase
        wdtLast = (startCfg.extra == cssu_pkg::EXTRA_64K) ?
                  WDT_CYC_64K - 17'h00001 : `CSSU_WDT_CYC_4K - 17'h00001;
    end

    assign srcDone = srcTick && cnt_q == srcLast;
    assign wdtDone = wdtTick && cnt_q == wdtLast;

    // source ticks first, watchdog ticks after, release last
    always_comb begin
        state_d = state_q;
        case (state_q)
            cssu_pkg::ST_CAPTURE:
                if (settle_q == `CSSU_SETTLE_CYC)
                    state_d = cssu_pkg::ST_SRC;
            cssu_pkg::ST_SRC:
                if (srcDone)
                    state_d = (fromReset_q && startCfg.extra != cssu_pkg::EXTRA_NONE) ?
                              cssu_pkg::ST_WDT : cssu_pkg::ST_RUN;
            cssu_pkg::ST_WDT:
                if (wdtDone)
                    state_d = cssu_pkg::ST_RUN;
            cssu_pkg::ST_RUN:
                if (sleepReq)
                    state_d = cssu_pkg::ST_SLEEP;
            cssu_pkg::ST_SLEEP:
                // oscillator stopped only in power-down and power-save
                if (wakeLvl)
                    state_d = (mode_q == cssu_pkg::SLP_POWER_DOWN ||
                               mode_q == cssu_pkg::SLP_POWER_SAVE) ?
                              cssu_pkg::ST_SRC : cssu_pkg::ST_RUN;
            default:
                state_d = cssu_pkg::ST_CAPTURE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q     <= cssu_pkg::ST_CAPTURE;
            fromReset_q <= 1'b1;
            mode_q      <= cssu_pkg::SLP_IDLE;
            cnt_q       <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == cssu_pkg::ST_RUN && sleepReq) begin
                mode_q      <= sleepMode;
                fromReset_q <= 1'b0;
            end
            // counter restarts on every state change
            if (state_d != state_q)
                cnt_q <= '0;
            else if ((state_q == cssu_pkg::ST_SRC && srcTick) ||
                     (state_q == cssu_pkg::ST_WDT && wdtTick))
                cnt_q <= cnt_q + 17'h00001;
        end
    end

    // ************************************************************
    // clock domain enables
    // ************************************************************
    cssu_pkg::cssu_domains_t domain_d;
    cssu_pkg::cssu_sleep_t   modeNext;

    assign modeNext = (state_q == cssu_pkg::ST_RUN && sleepReq) ? sleepMode : mode_q;

    // enables follow the next state so they line up with state_q
    always_comb begin
        domain_d = '0;
        case (state_d)
            cssu_pkg::ST_RUN:
                domain_d = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            cssu_pkg::ST_SLEEP:
                case (modeNext)
                    cssu_pkg::SLP_IDLE:        domain_d = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
                    cssu_pkg::SLP_ADC_NOISE:   domain_d = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
                    cssu_pkg::SLP_POWER_SAVE,
                    cssu_pkg::SLP_EXT_STANDBY: domain_d = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
                    default:                   domain_d = '0;
                endcase
            default:
                domain_d = '0;
        endcase
        domain_d.progMem = domain_d.core;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            domainEn            <= '0;
            startupBusy         <= 1'b1;
            // peripherals are off in reset, so async sensing must already be on
            asyncIrqSenseEn     <= 1'b1;
            twoWireAsyncMatchEn <= 1'b1;
        end else begin
            domainEn            <= domain_d;
            startupBusy         <= state_d != cssu_pkg::ST_RUN && state_d != cssu_pkg::ST_SLEEP;
            asyncIrqSenseEn     <= !domain_d.periph;
            twoWireAsyncMatchEn <= !domain_d.periph;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_core_only_run: assert property (state_q != cssu_pkg::ST_RUN |-> !domainEn.core)
        else $error("core domain running outside run state");
    a_flash_follows_core: assert property (domainEn.progMem == domainEn.core)
        else $error("program memory clock differs from core clock");
    a_periph_async_sense: assert property (!domainEn.periph |-> asyncIrqSenseEn)
        else $error("async interrupt sensing off with peripherals halted");
    a_twi_async_match: assert property (!domainEn.periph |-> twoWireAsyncMatchEn)
        else $error("two-wire async match off with peripherals halted");
    a_asy_power_save: assert property (state_q == cssu_pkg::ST_SLEEP &&
        mode_q == cssu_pkg::SLP_POWER_SAVE |-> domainEn.asyncTimer && !domainEn.periph)
        else $error("async timer stopped in power-save");
    a_adc_noise_mode: assert property (state_q == cssu_pkg::ST_SLEEP &&
        mode_q == cssu_pkg::SLP_ADC_NOISE |-> domainEn.converter && !domainEn.core &&
        !domainEn.periph)
        else $error("converter noise mode domains wrong");
    a_xtal_decode: assert property (fuseSel_q >= `CSSU_SEL_XTAL_MIN |=>
        sourceKind == cssu_pkg::SRC_XTAL)
        else $error("crystal select not decoded");
    a_swing_mode: assert property (##1 fullSwingMode == ($past(fuseAmp_q) == 1'b0))
        else $error("amplifier swing mode wrong");
    a_xtal_low_range: assert property (fuseSel_q[3:1] == `CSSU_RANGE_LO_CODE &&
        fuseAmp_q |=> freqRange == cssu_pkg::RNG_0M4_0M9)
        else $error("crystal low range wrong");
    a_wdt_after_src: assert property (state_q == cssu_pkg::ST_WDT |->
        $past(state_q) == cssu_pkg::ST_SRC || $past(state_q) == cssu_pkg::ST_WDT)
        else $error("watchdog count entered without source count");
    a_wdt_release: assert property (state_q == cssu_pkg::ST_WDT && wdtDone |=>
        state_q == cssu_pkg::ST_RUN && domainEn.core)
        else $error("no release after watchdog count");
    a_src_release: assert property (state_q == cssu_pkg::ST_SRC && srcDone &&
        !fromReset_q |=> state_q == cssu_pkg::ST_RUN && domainEn.periph)
        else $error("no release after wake-up count");

endmodule // cssu_clock_ctrl

// [verilog/cssu_regs.svh]
/*
 * Constants of the clock source select and start-up block: fuse field widths,
 * shipped fuse values and start-up cycle counts.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef CSSU_REGS_SVH
`define CSSU_REGS_SVH

// fuse field layout and values
`define CSSU_SEL_W          4
`define CSSU_SUT_W          2
`define CSSU_FUSE_PROG      1'h0
`define CSSU_SHIP_SEL       4'h1
`define CSSU_SHIP_SUT       2'h2
`define CSSU_SHIP_AMP       1'h1
`define CSSU_SEL_XTAL_MIN   4'ha
`define CSSU_SEL_LFXTAL     4'h9
`define CSSU_SEL_EXTRC_MIN  4'h5
`define CSSU_SEL_INTRC_MIN  4'h1
`define CSSU_SEL_EXTCLK     4'h0
`define CSSU_RANGE_LO_CODE  3'h5
`define CSSU_RANGE_MID_CODE 3'h6
`define CSSU_RANGE_HI_CODE  3'h7

// start-up counts, in source or watchdog cycles; the settle count in clk cycles
`define CSSU_CNT_W          17
`define CSSU_CYC_6          17'h00006
`define CSSU_CYC_18         17'h00012
`define CSSU_CYC_258        17'h00102
`define CSSU_CYC_1K         17'h00400
`define CSSU_CYC_16K        17'h04000
`define CSSU_CYC_32K        17'h08000
`define CSSU_WDT_CYC_4K     17'h01000
`define CSSU_WDT_CYC_64K    17'h10000
`define CSSU_SETTLE_CYC     2'h3

`endif

// [verilog/cssu_pkg.sv]
/*
 * Types of the clock source select and start-up block.
 * Assumes the constants header sits beside it.
 */
`include "cssu_regs.svh"
package cssu_pkg;
    typedef enum logic [2:0] {
        ST_CAPTURE = 3'h0, ST_SRC = 3'h1, ST_WDT = 3'h3, ST_RUN = 3'h2, ST_SLEEP = 3'h6
    } cssu_state_t;
    typedef enum logic [2:0] {
        SLP_IDLE = 3'h0, SLP_ADC_NOISE = 3'h1, SLP_POWER_DOWN = 3'h2,
        SLP_POWER_SAVE = 3'h3, SLP_STANDBY = 3'h6, SLP_EXT_STANDBY = 3'h7
    } cssu_sleep_t;
    typedef enum logic [2:0] {
        SRC_XTAL = 3'h0, SRC_LFXTAL = 3'h1, SRC_EXTRC = 3'h2,
        SRC_INTRC = 3'h3, SRC_EXTCLK = 3'h4
    } cssu_src_kind_t;
    typedef enum logic [2:0] {
        RNG_NONE = 3'h0, RNG_0M4_0M9 = 3'h1, RNG_0M9_3M0 = 3'h2,
        RNG_3M0_8M0 = 3'h3, RNG_1M0_UP = 3'h4
    } cssu_range_t;
    typedef enum logic [2:0] {
        CNT_6 = 3'h0, CNT_18 = 3'h1, CNT_258 = 3'h2, CNT_1K = 3'h3,
        CNT_16K = 3'h4, CNT_32K = 3'h5
    } cssu_src_cnt_t;
    typedef enum logic [1:0] {
        EXTRA_NONE = 2'h0, EXTRA_4K = 2'h1, EXTRA_64K = 2'h2
    } cssu_extra_t;
    typedef struct packed {
        logic core;
        logic periph;
        logic progMem;
        logic asyncTimer;
        logic converter;
    } cssu_domains_t;
    typedef struct packed {
        cssu_src_cnt_t srcCnt;
        cssu_extra_t   extra;
        logic          reserved;
    } cssu_startup_t;
endpackage

// [verif/cssu_osc_model.sv]
/*
 * Model of the oscillators on the far side: the selected source and the
 * watchdog oscillator, each gated by the bench and counting its ticks.
 * Assumes clk is the 40 MHz bench clock; the pins are async to the design.
 */
`timescale 1ns/1ps
module cssu_osc_model #(
    parameter int HALF = 2  // half period in clk cycles; 2 keeps every tick visible
) (
    // bench clock
    input  wire logic clk,
    // oscillator gating
    input  wire logic srcRun,
    input  wire logic wdtRun,
    // pins and tick counts
    output logic      sourceOscPin,
    output logic      watchdogOscPin,
    output int        srcTicks,
    output int        wdtTicks
);
    // ****************
    // oscillator core
    // ****************
    int ph;

    // a stopped oscillator rests low, so no stray edge is counted
    initial begin
        sourceOscPin = 1'h0;
        watchdogOscPin = 1'h0;
        srcTicks = 0;
        wdtTicks = 0;
        ph = 0;
    end

    // one shared phase: both oscillators tick at the same slow rate
    always @(posedge clk) begin
        ph <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
        if (ph == 0) begin
            sourceOscPin <= srcRun;
            watchdogOscPin <= wdtRun;
            srcTicks <= srcTicks + (srcRun ? 1 : 0);
            wdtTicks <= wdtTicks + (wdtRun ? 1 : 0);
        end else if (ph == HALF) begin
            sourceOscPin <= 1'h0;
            watchdogOscPin <= 1'h0;
        end
    end
endmodule // cssu_osc_model

// [verif/cssu_clock_ctrl_tb.sv]
/*
 * Self-checking bench of the clock source select and start-up block.
 * Assumes the oscillator model drives both oscillator pins.
 */
`timescale 1ns/1ps
module cssu_clock_ctrl_tb;
    // ****************
    // bench signals
    // ****************
    localparam int S16 = 32;
    localparam int S32 = 64;
    localparam int W64 = 128;
    logic                     clk = 1'h0;
    logic                     rstn = 1'h0;
    logic [3:0]               sel = 4'h1;
    logic [1:0]               sut = 2'h2;
    logic                     amp = 1'h1;
    logic                     sleepReq = 1'h0;
    cssu_pkg::cssu_sleep_t    sleepMode = cssu_pkg::SLP_IDLE;
    logic                     wakeEvent = 1'h0;
    logic                     srcRun = 1'h0;
    logic                     wdtRun = 1'h0;
    logic                     srcPin, wdtPin, busy, irqEn, twEn, swing, rsv;
    cssu_pkg::cssu_domains_t  dom;
    cssu_pkg::cssu_src_kind_t kind;
    cssu_pkg::cssu_range_t    rng;
    int                       srcTicks, wdtTicks, errors = 0, check_count = 0, cyc = 0;
    logic [6:0]               cfg [8] = '{7'h7a, 7'h55, 7'h63, 7'h4d, 7'h4f, 7'h29, 7'h07, 7'h3f};
    logic [2:0]               modes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h4};
    logic [4:0]               pats [7] = '{5'h0b, 5'h03, 5'h00, 5'h02, 5'h00, 5'h02, 5'h00};

    always #12.5 clk = ~clk;

    cssu_clock_ctrl #(.SRC_CYC_16K(17'h00020), .SRC_CYC_32K(17'h00040),
        .WDT_CYC_64K(17'h00080)) uut (.clk(clk), .rstn(rstn),
        .clockSourceSelectFuses(sel), .startupTimeFuses(sut), .amplifierSwingOption(amp),
        .sourceOscPin(srcPin), .watchdogOscPin(wdtPin), .sleepReq(sleepReq),
        .sleepMode(sleepMode), .wakeEvent(wakeEvent), .domainEn(dom), .startupBusy(busy),
        .asyncIrqSenseEn(irqEn), .twoWireAsyncMatchEn(twEn), .sourceKind(kind),
        .freqRange(rng), .fullSwingMode(swing), .cfgReserved(rsv));

    cssu_osc_model osc (.clk(clk), .srcRun(srcRun), .wdtRun(wdtRun), .sourceOscPin(srcPin),
        .watchdogOscPin(wdtPin), .srcTicks(srcTicks), .wdtTicks(wdtTicks));

    task automatic conclude();
        if (errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // a hang is cut short well above the longest expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            errors++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // source and watchdog tick counts expected for a fuse setting
    function automatic void counts(input logic [3:0] s, input logic [1:0] u,
                                   output int n, output int w);
        int xw[3] = '{4096, W64, 0};
        int rw[4] = '{0, 4096, W64, 4096};
        int iw[4] = '{0, 4096, W64, W64};
        n = 6;
        w = iw[u];
        if (s >= 4'ha) begin
            n = ({s[0], u} < 3'h2) ? 258 : ({s[0], u} < 3'h5) ? 1024 : S16;
            w = xw[{s[0], u} % 3];
        end else if (s == 4'h9) begin
            n = (u < 2'h2) ? 1024 : S32;
            w = (u == 2'h0) ? 4096 : W64;
        end else if (s >= 4'h5) begin
            n = (u == 2'h3) ? 6 : 18;
            w = rw[u];
        end
    endfunction

    function automatic logic [2:0] kindOf(input logic [3:0] s);
        return (s >= 4'ha) ? 3'h0 : (s == 4'h9) ? 3'h1 : (s >= 4'h5) ? 3'h2 : (s != 4'h0) ? 3'h3 : 3'h4;
    endfunction

    // reset with the given fuses, feed exactly the expected ticks, check release
    task automatic startUp(input logic [3:0] s, input logic [1:0] u, input logic a);
        int n, w, b;
        counts(s, u, n, w);
        sel = s;
        sut = u;
        amp = a;
        rstn = 1'h0;
        repeat (6) @(negedge clk);
        rstn = 1'h1;
        repeat (6) @(negedge clk);
        b = srcTicks;
        srcRun = 1'h1;
        while (srcTicks - b < n) @(negedge clk);
        srcRun = 1'h0;
        chk("busySrc", 8'h01, {7'h0, busy});
        chk("domStart", 8'h00, {3'h0, dom});
        if (w > 0) begin
            repeat (12) @(negedge clk);
            chk("busyHold", 8'h01, {7'h0, busy});
            b = wdtTicks;
            wdtRun = 1'h1;
            while (wdtTicks - b < w) @(negedge clk);
            wdtRun = 1'h0;
            chk("busyWdt", 8'h01, {7'h0, busy});
        end
        for (b = 0; b < 12 && busy !== 1'h0; b++) @(negedge clk);
        chk("release", 8'h1f, {3'h0, dom});
        chk("kind", {5'h0, kindOf(s)}, {5'h0, kind});
        chk("range", (s >= 4'ha) ? ((a == 1'h0) ? 8'h04 : {5'h0, s[3:1] - 3'h4}) : 8'h00,
            {5'h0, rng});
        chk("swing", {7'h0, ~a}, {7'h0, swing});
        chk("reserved", {7'h0, u == 2'h3 && (s < 4'h5 || s == 4'h9)}, {7'h0, rsv});
    endtask

    // enter a sleep mode, check the domain pattern, then wake
    task automatic sleepWake(input logic [2:0] m, input logic [4:0] p);
        int b;
        @(negedge clk);
        sleepReq = 1'h1;
        sleepMode = cssu_pkg::cssu_sleep_t'(m);
        @(negedge clk);
        sleepReq = 1'h0;
        chk("sleepDom", {3'h0, p}, {3'h0, dom});
        chk("irqSense", {7'h0, ~p[3]}, {7'h0, irqEn});
        chk("twoWire", {7'h0, ~p[3]}, {7'h0, twEn});
        wakeEvent = 1'h1;
        repeat (8) @(negedge clk);
        wakeEvent = 1'h0;
        if (m == 3'h2 || m == 3'h3) begin
            chk("wakeHold", 8'h00, {3'h0, dom});
            b = srcTicks;
            srcRun = 1'h1;
            while (srcTicks - b < 6) @(negedge clk);
            srcRun = 1'h0;
            chk("wakeCount", 8'h01, {7'h0, busy});
            repeat (4) @(negedge clk);
        end
        chk("wake", 8'h1f, {3'h0, dom});
    endtask

    initial begin
        void'($urandom(51919));
        for (int i = 0; i < 8; i++) startUp(cfg[i][6:3], cfg[i][2:1], cfg[i][0]);
        repeat (2) startUp(4'($urandom), 2'($urandom), 1'($urandom));
        startUp(4'h1, 2'h2, 1'h1);
        for (int i = 0; i < 7; i++) sleepWake(modes[i], pats[i]);
        conclude();
    end
endmodule // cssu_clock_ctrl_tb
